// ==== core/tpc_timer_pwm.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "tpc_params.svh"

module tpc_timer_pwm (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // System state
    input  wire logic                   wait_mode,
    input  wire logic                   break_active,
    input  wire logic                   ext_clk_pin,
    // Requests to the processor
    output logic                        irq_req,
    output logic                        wake_req,
    // Channel pins
    output tpc_pkg::tpc_pin_type        chan0_pin,
    output tpc_pkg::tpc_pin_type        chan1_pin
);

    localparam int PW = `TPC_PRE_W;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic                       ovf_flag_r,  ovf_flag_nxt;
    logic                       ovf_ie_r,    ovf_ie_nxt;
    logic                       stop_r,      stop_nxt;
    logic [2:0]                 ps_r,        ps_nxt;
    logic [15:0]                cnt_r,       cnt_nxt;
    logic [15:0]                mod_r,       mod_nxt;
    logic [PW-1:0]              pre_r,       pre_nxt;
    tpc_pkg::tpc_chan_cfg_type  cfg_r [2];
    tpc_pkg::tpc_chan_cfg_type  cfg_nxt [2];
    logic [15:0]                cmp_r [2];
    logic [15:0]                cmp_nxt [2];
    logic [1:0]                 cf_r,        cf_nxt;
    logic [1:0]                 arm_cf_r,    arm_cf_nxt;
    logic                       arm_ovf_r,   arm_ovf_nxt;
    logic                       break_clear_enable_r,      break_clear_enable_nxt;
    logic [1:0]                 pin_r,       pin_nxt;
    logic                       sel_r,       sel_nxt;
    logic                       last_wr_r,   last_wr_nxt;
    logic [31:0]                prdata_r,    prdata_nxt;
    logic                       ext_s1_r,    ext_s2_r,    ext_s3_r;

    ////////////////////////////////////////////////////////////////////////
    // Decode and timing

    logic               acc;
    logic               wr;
    logic               rd;
    logic               mapped;
    logic               clr_ok;
    logic               run;
    logic               tick;
    logic               ovf_evt;
    logic               linked;
    logic [PW-1:0]      mask;
    logic [1:0]         cmp_en;
    logic [1:0]         cmp_evt;
    logic [15:0]        cnt_step;
    logic [15:0]        act_val [2];

    // Flag with two-step clear; a new event wins over the clear
    function automatic logic [1:0] flag_upd(
        input logic f,
        input logic a,
        input logic evt,
        input logic rd_hit,
        input logic wr0,
        input logic ok
    );
        logic nf;
        logic na;
        nf = evt | (f & ~(a & wr0 & ok));
        na = a;
        if (evt) begin
            na = 1'b0;
        end else if (a & wr0 & ok) begin
            na = 1'b0;
        end else if (rd_hit & f & ok) begin
            na = 1'b1;
        end
        return {nf, na};
    endfunction

    always_comb begin
        mapped = paddr[1:0] == 2'b00 && paddr <= `TPC_OFF_BRK;
        acc    = psel & penable & ~wait_mode & mapped;
        wr     = acc & pwrite;
        rd     = acc & ~pwrite;
        clr_ok = ~break_active | break_clear_enable_r;
        run    = ~stop_r & ~break_active;
        mask   = PW'((8'h01 << ps_r) - 8'h01);
        if (ps_r == `TPC_PS_EXT) begin
            tick = run & ext_s2_r & ~ext_s3_r;
        end else begin
            tick = run & ((pre_r & mask) == mask);
        end
        ovf_evt = tick & (cnt_r == mod_r);
        cnt_step = ovf_evt ? 16'h0000 : cnt_r + 16'h0001;
        linked  = cfg_r[0].buffer_link;
        act_val[0] = (linked & sel_r) ? cmp_r[1] : cmp_r[0];
        act_val[1] = cmp_r[1];
        // Link bit alone selects compare mode on channel 0
        cmp_en[0] = (cfg_r[0].buffer_link | cfg_r[0].mode_bit_a)
                  & (cfg_r[0].edge_level_b | cfg_r[0].edge_level_a);
        cmp_en[1] = ~linked & cfg_r[1].mode_bit_a
                  & (cfg_r[1].edge_level_b | cfg_r[1].edge_level_a);
        for (int i = 0; i < 2; i++) begin
            // Exact match only: a value passed by a late write is missed
            // Match on the value being entered, so width equals compare
            cmp_evt[i] = tick & cmp_en[i]
                       & (cnt_step == act_val[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [1:0] fu;
        logic       wr_tsc;
        logic       ch_wr;
        fu          = 2'b00;
        wr_tsc      = wr && paddr == `TPC_OFF_TSC;
        ch_wr       = 1'b0;
        ovf_ie_nxt  = ovf_ie_r;
        stop_nxt    = stop_r;
        ps_nxt      = ps_r;
        mod_nxt     = mod_r;
        cfg_nxt     = cfg_r;
        cmp_nxt     = cmp_r;
        cf_nxt      = cf_r;
        arm_cf_nxt  = arm_cf_r;
        break_clear_enable_nxt    = break_clear_enable_r;
        pin_nxt     = pin_r;
        sel_nxt     = sel_r;
        last_wr_nxt = last_wr_r;
        prdata_nxt  = prdata_r;

        // Counter and prescaler
        pre_nxt = run ? PW'(pre_r + 1'b1) : pre_r;
        if (ovf_evt) begin
            cnt_nxt = 16'h0000;
        end else if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end else begin
            cnt_nxt = cnt_r;
        end
        if (wr_tsc && pwdata[`TPC_TSC_TRST]) begin
            cnt_nxt = 16'h0000;
            pre_nxt = '0;
        end

        // Overflow flag
        fu = flag_upd(ovf_flag_r, arm_ovf_r, ovf_evt,
                      rd && paddr == `TPC_OFF_TSC,
                      wr_tsc && !pwdata[`TPC_TSC_OVF], clr_ok);
        ovf_flag_nxt = fu[1];
        arm_ovf_nxt  = fu[0];

        // Register writes
        if (wr) begin
            unique case (paddr)
                `TPC_OFF_TSC: begin
                    ovf_ie_nxt = pwdata[`TPC_TSC_OIE];
                    stop_nxt   = pwdata[`TPC_TSC_STOP];
                    ps_nxt     = pwdata[`TPC_TSC_PS_HI:`TPC_TSC_PS_LO];
                end
                `TPC_OFF_MOD: mod_nxt = pwdata[15:0];
                `TPC_OFF_SC0: cfg_nxt[0] =
                    pwdata[`TPC_SC_CFG_HI:`TPC_SC_CFG_LO];
                `TPC_OFF_SC1: begin
                    if (!linked) begin
                        cfg_nxt[1] = pwdata[`TPC_SC_CFG_HI:`TPC_SC_CFG_LO];
                        cfg_nxt[1].buffer_link = 1'b0;
                    end
                end
                `TPC_OFF_CH0: begin
                    cmp_nxt[0]  = pwdata[15:0];
                    last_wr_nxt = 1'b0;
                    ch_wr       = 1'b1;
                end
                `TPC_OFF_CH1: begin
                    cmp_nxt[1]  = pwdata[15:0];
                    last_wr_nxt = 1'b1;
                    ch_wr       = 1'b1;
                end
                `TPC_OFF_BRK: break_clear_enable_nxt = pwdata[`TPC_BRK_BREAK_CLEAR_ENABLE];
                default: ;
            endcase
        end

        // Channel flags
        for (int i = 0; i < 2; i++) begin
            fu = flag_upd(cf_r[i], arm_cf_r[i], cmp_evt[i],
                 rd && paddr == (i == 0 ? `TPC_OFF_SC0 : `TPC_OFF_SC1),
                 wr && !pwdata[`TPC_SC_FLAG] &&
                 paddr == (i == 0 ? `TPC_OFF_SC0 : `TPC_OFF_SC1),
                 clr_ok);
            cf_nxt[i]     = fu[1];
            arm_cf_nxt[i] = fu[0];
        end
        if (linked) begin
            cf_nxt[1]     = 1'b0;
            arm_cf_nxt[1] = 1'b0;
        end

        // Active compare register swaps only at overflow while linked; clearing the link returns channel 0 to CH0 at once
        if (!linked) begin
            sel_nxt = 1'b0;
        end else if (ovf_evt) begin
            sel_nxt = ch_wr ? last_wr_nxt : last_wr_r;
        end

        // Pin actions; a compare in the overflow tick wins
        for (int i = 0; i < 2; i++) begin
            if (cfg_r[i].max_duty && cfg_r[i].toggle_on_overflow) begin
                pin_nxt[i] = ~cfg_r[i].edge_level_a;
            end else begin
                if (ovf_evt && cfg_r[i].toggle_on_overflow) begin
                    pin_nxt[i] = ~pin_r[i];
                end
                if (cmp_evt[i]) begin
                    unique case ({cfg_r[i].edge_level_b,
                                  cfg_r[i].edge_level_a})
                        2'b01:   pin_nxt[i] = ~pin_r[i];
                        2'b10:   pin_nxt[i] = 1'b0;
                        2'b11:   pin_nxt[i] = 1'b1;
                        default: ;
                    endcase
                end
            end
        end

        // Read data captured in the setup cycle
        if (psel && !penable && !pwrite) begin
            prdata_nxt = 32'h0000_0000;
            if (!wait_mode) begin
                unique case (paddr)
                    `TPC_OFF_TSC: begin
                        prdata_nxt[`TPC_TSC_OVF]  = ovf_flag_r;
                        prdata_nxt[`TPC_TSC_OIE]  = ovf_ie_r;
                        prdata_nxt[`TPC_TSC_STOP] = stop_r;
                        prdata_nxt[`TPC_TSC_PS_HI:`TPC_TSC_PS_LO] = ps_r;
                    end
                    `TPC_OFF_CNT: prdata_nxt[15:0] = cnt_r;
                    `TPC_OFF_MOD: prdata_nxt[15:0] = mod_r;
                    `TPC_OFF_SC0: prdata_nxt[7:0] = {cf_r[0], cfg_r[0]};
                    `TPC_OFF_SC1: prdata_nxt[7:0] = {cf_r[1], cfg_r[1]};
                    `TPC_OFF_CH0: prdata_nxt[15:0] = cmp_r[0];
                    `TPC_OFF_CH1: prdata_nxt[15:0] = cmp_r[1];
                    `TPC_OFF_BRK: prdata_nxt[`TPC_BRK_BREAK_CLEAR_ENABLE] = break_clear_enable_r;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_r <= 1'b0;
            ovf_ie_r   <= 1'b0;
            stop_r     <= `TPC_RST_STOP;
            ps_r       <= `TPC_RST_PS;
            cnt_r      <= 16'h0000;
            mod_r      <= `TPC_RST_MOD;
            pre_r      <= '0;
            cfg_r[0]   <= '0;
            cfg_r[1]   <= '0;
            cmp_r[0]   <= 16'h0000;
            cmp_r[1]   <= 16'h0000;
            cf_r       <= 2'b00;
            arm_cf_r   <= 2'b00;
            arm_ovf_r  <= 1'b0;
            break_clear_enable_r     <= 1'b0;
            pin_r      <= 2'b00;
            sel_r      <= 1'b0;
            last_wr_r  <= 1'b0;
            prdata_r   <= 32'h0000_0000;
            ext_s1_r   <= 1'b0;
            ext_s2_r   <= 1'b0;
            ext_s3_r   <= 1'b0;
        end else begin
            ovf_flag_r <= ovf_flag_nxt;
            ovf_ie_r   <= ovf_ie_nxt;
            stop_r     <= stop_nxt;
            ps_r       <= ps_nxt;
            cnt_r      <= cnt_nxt;
            mod_r      <= mod_nxt;
            pre_r      <= pre_nxt;
            cfg_r      <= cfg_nxt;
            cmp_r      <= cmp_nxt;
            cf_r       <= cf_nxt;
            arm_cf_r   <= arm_cf_nxt;
            arm_ovf_r  <= arm_ovf_nxt;
            break_clear_enable_r     <= break_clear_enable_nxt;
            pin_r      <= pin_nxt;
            sel_r      <= sel_nxt;
            last_wr_r  <= last_wr_nxt;
            prdata_r   <= prdata_nxt;
            ext_s1_r   <= ext_clk_pin;
            ext_s2_r   <= ext_s1_r;
            ext_s3_r   <= ext_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        prdata  = prdata_r;
        pready  = 1'b1;
        // Wait mode or an unmapped address answers with an error
        pslverr = psel & penable & (wait_mode | ~mapped);
        irq_req = (ovf_flag_r & ovf_ie_r)
                | (cf_r[0] & cfg_r[0].irq_enable)
                | (cf_r[1] & cfg_r[1].irq_enable);
        wake_req = wait_mode & irq_req;
        chan0_pin.out = pin_r[0];
        chan0_pin.oe  = cmp_en[0];
        chan1_pin.out = pin_r[1];
        chan1_pin.oe  = cmp_en[1];
    end

endmodule
`default_nettype wire

// ==== common/tpc_params.svh ====
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

// Byte offsets of the registers
`define TPC_OFF_TSC      8'h00
`define TPC_OFF_CNT      8'h04
`define TPC_OFF_MOD      8'h08
`define TPC_OFF_SC0      8'h0C
`define TPC_OFF_CH0      8'h10
`define TPC_OFF_SC1      8'h14
`define TPC_OFF_CH1      8'h18
`define TPC_OFF_BRK      8'h1C

// Timer control and status fields
`define TPC_TSC_OVF      7
`define TPC_TSC_OIE      6
`define TPC_TSC_STOP     5
`define TPC_TSC_TRST     4
`define TPC_TSC_PS_HI    2
`define TPC_TSC_PS_LO    0

// Channel control and status fields
`define TPC_SC_FLAG      7
`define TPC_SC_CFG_HI    6
`define TPC_SC_CFG_LO    0

// Break flag control field
`define TPC_BRK_BREAK_CLEAR_ENABLE     0

// Reset values
`define TPC_RST_MOD      16'hFFFF
`define TPC_RST_STOP     1'b1
`define TPC_RST_PS       3'h0

// Prescaler code that selects the external clock pin
`define TPC_PS_EXT       3'h7
`define TPC_PRE_W        7

`endif

// ==== common/tpc_pkg.sv ====
package tpc_pkg;

    // Channel configuration, bit 6 down to bit 0 of a channel register
    typedef struct packed {
        logic irq_enable;
        logic buffer_link;
        logic mode_bit_a;
        logic edge_level_b;
        logic edge_level_a;
        logic toggle_on_overflow;
        logic max_duty;
    } tpc_chan_cfg_type;

    // Pins of one channel
    typedef struct packed {
        logic out;
        logic oe;
    } tpc_pin_type;

endpackage

// ==== sim/tpc_timer_pwm_sva.sv ====
`timescale 1ns/1ns
`default_nettype none

module tpc_timer_pwm_chk (
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // System state
    input wire logic                 wait_mode,
    input wire logic                 break_active,
    input wire logic                 ext_clk_pin,
    // Requests and pins
    input wire logic                 irq_req,
    input wire logic                 wake_req,
    input wire tpc_pkg::tpc_pin_type chan0_pin,
    input wire tpc_pkg::tpc_pin_type chan1_pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cfg_wr;
        psel && penable && pwrite && !wait_mode && paddr == 8'h0C;
    endsequence
    sequence s_tsc_rd;
        psel && !penable && !pwrite && !wait_mode && paddr == 8'h00;
    endsequence

    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_wake_follow: assert property (wake_req == (wait_mode && irq_req))
        else $error("wake request mismatch");
    chk_wait_refuse: assert property (psel && penable && wait_mode |-> pslverr)
        else $error("access in wait mode not refused");
    chk_wait_read: assert property (psel && !penable && !pwrite && wait_mode
        |=> prdata == 32'h0000_0000)
        else $error("read in wait mode returned data");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
        else $error("unmapped access not refused");
    chk_trst_zero: assert property (s_tsc_rd |=> !prdata[4] && prdata[31:8] == 24'h00_0000)
        else $error("reset bit read back set");
    chk_break_hold: assert property ($past(break_active) && !$past(psel) |-> $stable(chan0_pin.out) && $stable(chan1_pin.out))
        else $error("pin moved during break");
    chk_link_frees: assert property (s_cfg_wr ##0 pwdata[5] |=> !chan1_pin.oe)
        else $error("channel 1 pin still driven while linked");
    chk_cmp_drives: assert property (s_cfg_wr ##0 pwdata[4:3] == 2'b11 |=> chan0_pin.oe)
        else $error("channel 0 pin not driven in compare mode");
    // Forced level needs no timer tick and shows two clocks after the write; the window is loose
    chk_full_duty: assert property (s_cfg_wr ##0 (pwdata[5:0] == 6'h1B && !break_active) |-> ##[1:300] chan0_pin.out)
        else $error("full duty output not high");
endmodule

bind tpc_timer_pwm tpc_timer_pwm_chk i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_mode(wait_mode), .break_active(break_active),
    .ext_clk_pin(ext_clk_pin), .irq_req(irq_req), .wake_req(wake_req),
    .chan0_pin(chan0_pin), .chan1_pin(chan1_pin));

`default_nettype wire

// ==== sim/tpc_pin_load.sv ====
`timescale 1ns/1ns
`default_nettype none

// Load on the channel pin: counts driven-high cycles and rising edges
module tpc_pin_load (
    // Clock and window control
    input wire logic                 pclk,
    input wire logic                 clr,
    // Observed pin
    input wire tpc_pkg::tpc_pin_type pin,
    // Measurements
    output logic [15:0]              hi_cnt,
    output logic [15:0]              rises
);
    logic lvl;
    logic prev;

    // An undriven pin reads low, as through a pull-down
    assign lvl = pin.oe & pin.out;

    always_ff @(posedge pclk) begin
        prev <= lvl;
        if (clr) begin
            hi_cnt <= 16'h0000;
            rises  <= 16'h0000;
        end else begin
            hi_cnt <= hi_cnt + {15'h0000, lvl};
            rises  <= rises + {15'h0000, lvl & ~prev};
        end
    end
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic [31:0]          rd;
    logic                 pready;
    logic                 pslverr;
    logic                 err;
    logic                 wait_mode;
    logic                 break_active;
    logic                 irq_req;
    logic                 wake_req;
    logic                 clr;
    logic [15:0]          hi_cnt;
    logic [15:0]          rises;
    tpc_pkg::tpc_pin_type chan0_pin;
    tpc_pkg::tpc_pin_type chan1_pin;
    int                   error_cnt;
    int                   checked;
    int                   cyc;

    tpc_timer_pwm i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_mode(wait_mode), .break_active(break_active),
        .ext_clk_pin(1'b0), .irq_req(irq_req), .wake_req(wake_req),
        .chan0_pin(chan0_pin), .chan1_pin(chan1_pin));

    tpc_pin_load i_load (.pclk(pclk), .clr(clr), .pin(chan0_pin),
        .hi_cnt(hi_cnt), .rises(rises));

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d, checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(string nm, logic e, logic g);
        cmp_word(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Whole number of periods, so phase does not matter
    task automatic window(logic [15:0] e_hi, logic [15:0] e_rise);
        repeat (600) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (512) @(posedge pclk);
        #1;
        cmp_word("high cycles", {16'h0000, e_hi}, {16'h0000, hi_cnt});
        cmp_word("rising edges", {16'h0000, e_rise}, {16'h0000, rises});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(8'h00, 1'b0, 32'h0000_0000);
        cmp_word("tsc", 32'h0000_0020, rd);
        apb(8'h08, 1'b0, 32'h0000_0000);
        cmp_word("modulo", 32'h0000_FFFF, rd);
        apb(8'h20, 1'b0, 32'h0000_0000);
        cmp_bit("unmapped err", 1'b1, err);
    endtask

    // Period 256, compare 128: half of each period high
    task automatic t_pwm_half();
        apb(8'h00, 1'b1, 32'h0000_0030);
        apb(8'h08, 1'b1, 32'h0000_00FF);
        apb(8'h10, 1'b1, 32'h0000_0080);
        apb(8'h0C, 1'b1, 32'h0000_001A);
        apb(8'h00, 1'b1, 32'h0000_0000);
        window(16'h0100, 16'h0002);
        apb(8'h0C, 1'b0, 32'h0000_0000);
        cmp_word("chan0 status", 32'h0000_009A, rd);
        // Longer width written just after an overflow
        apb(8'h00, 1'b0, 32'h0000_0000);
        apb(8'h00, 1'b1, 32'h0000_0000);
        rd = 32'h0000_0000;
        while (rd[7] !== 1'b1) begin
            apb(8'h00, 1'b0, 32'h0000_0000);
        end
        apb(8'h10, 1'b1, 32'h0000_00C0);
        window(16'h0180, 16'h0002);
    endtask

    task automatic t_zero_full();
        apb(8'h0C, 1'b1, 32'h0000_0018);
        window(16'h0000, 16'h0000);
        apb(8'h0C, 1'b1, 32'h0000_001B);
        window(16'h0200, 16'h0000);
    endtask

    task automatic t_buffered();
        apb(8'h14, 1'b1, 32'h0000_0018);
        cmp_bit("chan1 oe on", 1'b1, chan1_pin.oe);
        repeat (300) @(posedge pclk);
        apb(8'h14, 1'b0, 32'h0000_0000);
        cmp_word("chan1 status", 32'h0000_0098, rd);
        apb(8'h0C, 1'b1, 32'h0000_003A);
        cmp_bit("chan1 oe", 1'b0, chan1_pin.oe);
        apb(8'h18, 1'b1, 32'h0000_0040);
        window(16'h0080, 16'h0002);
        apb(8'h14, 1'b0, 32'h0000_0000);
        cmp_bit("chan1 flag", 1'b0, rd[7]);
    endtask

    task automatic t_flags();
        apb(8'h00, 1'b1, 32'h0000_00E0);
        cmp_bit("irq", 1'b1, irq_req);
        wait_mode <= 1'b1;
        apb(8'h00, 1'b0, 32'h0000_0000);
        cmp_bit("wait err", 1'b1, err);
        cmp_word("wait read", 32'h0000_0000, rd);
        cmp_bit("wake", 1'b1, wake_req);
        wait_mode <= 1'b0;
        apb(8'h00, 1'b0, 32'h0000_0000);
        cmp_word("tsc armed", 32'h0000_00E0, rd);
        break_active <= 1'b1;
        apb(8'h00, 1'b1, 32'h0000_0060);
        apb(8'h00, 1'b0, 32'h0000_0000);
        cmp_word("tsc in break", 32'h0000_00E0, rd);
        break_active <= 1'b0;
        apb(8'h00, 1'b1, 32'h0000_0060);
        apb(8'h00, 1'b0, 32'h0000_0000);
        cmp_word("tsc cleared", 32'h0000_0060, rd);
        cmp_bit("irq off", 1'b0, irq_req);
        // Clear enabled during break: the cleared flag must stay clear
        apb(8'h1C, 1'b1, 32'h0000_0001);
        break_active <= 1'b1;
        apb(8'h0C, 1'b0, 32'h0000_0000);
        cmp_word("chan0 flag set", 32'h0000_00BA, rd);
        apb(8'h0C, 1'b1, 32'h0000_003A);
        break_active <= 1'b0;
        apb(8'h0C, 1'b0, 32'h0000_0000);
        cmp_word("chan0 flag kept clear", 32'h0000_003A, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        wait_mode = 1'b0;
        break_active = 1'b0;
        clr = 1'b0;
        error_cnt = 0;
        checked = 0;
        cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_pwm_half();
        t_zero_full();
        t_buffered();
        t_flags();
        finish_test();
    end
endmodule

`default_nettype wire
